/* File: logic/disp_pkg.sv */
// Display path constants, register map and carriers
package disp_pkg;
	// Register map, one 16-bit word each
	localparam logic [6:0] CHR_CFG   = 7'h00;
	localparam logic [6:0] CTI_CFG   = 7'h01;
	localparam logic [6:0] COEF_MAIN = 7'h02;
	localparam logic [6:0] COEF_SIDE = 7'h08;
	localparam logic [6:0] WDRIVE    = 7'h0e;
	localparam logic [6:0] OSD_AMP   = 7'h11;
	localparam logic [6:0] BRD_COL   = 7'h14;
	localparam logic [6:0] BRD_CON   = 7'h15;
	localparam logic [6:0] BRD_RANK  = 7'h16;
	localparam logic [6:0] BRD_LEFT  = 7'h17;
	localparam logic [6:0] BRD_RIGHT = 7'h18;
	localparam logic [6:0] BRD_TOP   = 7'h19;
	localparam logic [6:0] BRD_BOT   = 7'h1a;
	localparam logic [6:0] H_ACTIVE  = 7'h1b;
	localparam logic [6:0] V_ACTIVE  = 7'h1c;
	localparam logic [6:0] VEL_SET0  = 7'h1d;
	localparam logic [6:0] VEL_SET1  = 7'h1e;
	localparam logic [6:0] VEL_CORE  = 7'h1f;
	localparam logic [6:0] VEL_DLY   = 7'h20;
	localparam logic [6:0] STATUS    = 7'h21;
	localparam logic [6:0] OSD_TAB   = 7'h30;
	localparam logic [6:0] RANK_TAB  = 7'h40;
	// Field positions
	localparam int CHR_INV_BIT  = 0;
	localparam int CHR_TWOS_BIT = 1;
	localparam int CHR_DLY_LSB  = 2;
	localparam int CTI_COMP_BIT = 8;
	localparam int CTL_SIDE     = 0;
	localparam int CTL_TAB      = 1;
	localparam int CTL_BEXP     = 2;
	localparam int CTL_PEAK     = 3;
	localparam int CTL_FB1      = 4;
	localparam int CTL_FB2      = 5;
	// Values after reset
	localparam logic [15:0] CHR_RST  = 16'h0008;
	localparam logic [15:0] CTI_RST  = 16'h0024;
	localparam logic [15:0] GAIN_RST = 16'h0080;
	localparam logic [15:0] HACT_RST = 16'h02d0;
	localparam logic [15:0] VACT_RST = 16'h0120;
	localparam logic [15:0] VEL_RST  = 16'h0042;
	localparam logic [15:0] SVC_RST  = 16'h07f2;
	localparam logic [15:0] SVD_RST  = 16'h0007;
	localparam logic [15:0] COEF_RST [0:5] = '{16'h0000, 16'h005a, 16'h01ea, 16'h01d2, 16'h0071, 16'h0000};
	// Pipeline depths in cycles
	localparam int SIDE_LAT = 7;
	localparam int SV_DEPTH = 8;
	typedef struct packed {
		logic [9:0] luma;
		logic [4:0] osd;
		logic [2:0] rank;
		logic       border;
	} side_s;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [15:0] data;
	} reg_req_s;
endpackage : disp_pkg

/* File: logic/display_chroma_rgb_osd_pipeline.sv */
// Chroma, matrix, RGB, OSD, frame, priority and velocity modulation path
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - Chroma input is 8-bit, Cb and Cr alternating, binary offset by default
// RULE2 - Chroma may be inverted and read as two's complement or offset
// RULE3 - Chroma delay versus luma in five steps from -2 to +2 clocks
// RULE4 - Linear-phase interpolation from half rate to full rate chroma
// RULE5 - Transient correction from differentiated chroma, selectable bandwidth and gain
// RULE6 - Small corrections cored away; sharpened chroma clamped to neighbours
// RULE7 - Six signed 9-bit coefficients form R-Y, G-Y, B-Y from Cb, Cr
// RULE8 - Main and side coefficient sets selected per pixel
// RULE9 - Luma added to colour differences, RGB saturated to 10 bits
// RULE10 - Per-channel white drive multipliers also apply beam current attenuation
// RULE11 - Five OSD lines address a 32-entry colour table
// RULE12 - Top bit low: fixed full colours, bit 3 halves contrast
// RULE13 - Top bit high: sixteen host-loaded colours indexed by low bits
// RULE14 - OSD colours scaled per channel; priority selects video or table
// RULE15 - Border widths programmable, running from right/bottom through flyback
// RULE16 - Border colour is 3x4-bit RGB with its own contrast
// RULE17 - Border drawn only where its priority beats the bus priority
// RULE18 - Three priority lines, eight levels, all low is highest
// RULE19 - Each level maps to programmable picture, OSD and blanking controls
// RULE20 - Velocity path: RGB to luma, 1-z^-N filter, coring, gain, limiter
// RULE21 - Velocity output delay +-3.5 clocks in half-clock steps
// RULE22 - Two velocity parameter sets switched by the video/table select
// RULE23 - OSD lines arrive synchronous to the display clock
// RULE24 - Luma, chroma, OSD and priority latencies are equalised
module display_chroma_rgb_osd_pipeline (
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic [6:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic [7:0]  chroma_in,
	input  wire logic        chroma_cr_in,
	input  wire logic [9:0]  luma_in,
	input  wire logic [4:0]  osd_in,
	input  wire logic [2:0]  overlay_rank_bus_in,
	input  wire logic [10:0] hpos_in,
	input  wire logic [9:0]  vpos_in,
	input  wire logic [7:0]  abl_atten_in,
	output logic      [9:0]  red_out,
	output logic      [9:0]  green_out,
	output logic      [9:0]  blue_out,
	output logic      [7:0]  beam_velocity_modulation_out,
	output logic             side_sel_out,
	output logic             table_sel_out,
	output logic             black_exp_en_out,
	output logic             peak_supp_out,
	output logic             fblank1_en_out,
	output logic             fblank2_en_out
);

	// ==========================================
	// Register file
	disp_pkg::reg_req_s req;
	logic [15:0]        regs_r [0:127];
	logic [15:0]        rdata_r;
	logic               brd_r;
	logic [2:0]         rank_r;

	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, data: reg_wdata_in};

	function automatic logic [15:0] reset_of(input logic [6:0] a);
		logic [6:0] m;
		logic [6:0] s;
		m = a - disp_pkg::COEF_MAIN;
		s = a - disp_pkg::COEF_SIDE;
		reset_of = 16'h0000;
		if (m < 7'h06) begin
			reset_of = disp_pkg::COEF_RST[m[2:0]];
		end else if (s < 7'h06) begin
			reset_of = disp_pkg::COEF_RST[s[2:0]];
		end else begin
			case (a)
				disp_pkg::CHR_CFG: reset_of = disp_pkg::CHR_RST;
				disp_pkg::CTI_CFG: reset_of = disp_pkg::CTI_RST;
				disp_pkg::WDRIVE, 7'h0f, 7'h10: reset_of = disp_pkg::GAIN_RST;
				disp_pkg::OSD_AMP, 7'h12, 7'h13: reset_of = disp_pkg::GAIN_RST;
				disp_pkg::BRD_CON: reset_of = disp_pkg::GAIN_RST;
				disp_pkg::H_ACTIVE: reset_of = disp_pkg::HACT_RST;
				disp_pkg::V_ACTIVE: reset_of = disp_pkg::VACT_RST;
				disp_pkg::VEL_SET0, disp_pkg::VEL_SET1: reset_of = disp_pkg::VEL_RST;
				disp_pkg::VEL_CORE: reset_of = disp_pkg::SVC_RST;
				disp_pkg::VEL_DLY: reset_of = disp_pkg::SVD_RST;
				default: reset_of = 16'h0000;
			endcase
		end
	endfunction : reset_of

	// RULE13 table loaded by host
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < 128; i++) begin
				regs_r[i] <= reset_of(7'(i));
			end
		end else if (req.wr && req.addr != disp_pkg::STATUS) begin
			regs_r[req.addr] <= req.data;
		end
	end

	wire [15:0] status_w = {12'h000, brd_r, rank_r};
	wire [15:0] rd_sel   = (req.addr == disp_pkg::STATUS) ? status_w : regs_r[req.addr];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= req.rd ? rd_sel : 16'h0000;
		end
	end

	assign reg_rdata_out = rdata_r;

	// ==========================================
	// Chroma input and delay
	wire [15:0] chr_cfg  = regs_r[disp_pkg::CHR_CFG];
	wire [15:0] cti_cfg  = regs_r[disp_pkg::CTI_CFG];
	wire        chr_inv  = chr_cfg[disp_pkg::CHR_INV_BIT];
	wire        chr_twos = chr_cfg[disp_pkg::CHR_TWOS_BIT];
	wire [2:0]  dly_code = chr_cfg[disp_pkg::CHR_DLY_LSB +: 3];
	// RULE1 offset to signed
	wire [7:0]  ch_tc    = chr_twos ? chroma_in : (chroma_in ^ 8'h80);
	// RULE2 optional inversion
	wire [7:0]  ch_neg   = (ch_tc == 8'h80) ? 8'h7f : (8'h00 - ch_tc);
	// RULE3 tap clamped to five steps
	wire [2:0]  dly_sel  = (dly_code > 3'h4) ? 3'h4 : dly_code;
	logic [8:0] cdl_r [0:4];
	wire [8:0]  tap      = cdl_r[dly_sel];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < 5; i++) begin
				cdl_r[i] <= 9'h000;
			end
		end else begin
			cdl_r[0] <= {chroma_cr_in, chr_inv ? ch_neg : ch_tc};
			for (int i = 1; i < 5; i++) begin
				cdl_r[i] <= cdl_r[i-1];
			end
		end
	end

	// ==========================================
	// Interpolation and transient improvement
	logic signed [7:0] chr_q [0:1];
	wire  [3:0]        cti_gain = cti_cfg[3:0];
	wire  [3:0]        cti_core = cti_cfg[7:4];
	wire               cti_comp = cti_cfg[disp_pkg::CTI_COMP_BIT];

	generate
		for (genvar c = 0; c < 2; c++) begin : g_comp
			logic signed [7:0] s1_r, x0_r, x1_r, x2_r, x3_r, x4_r, cti_r;
			wire               newc = (tap[8] == 1'(c));
			wire signed [8:0]  avs  = {s1_r[7], s1_r} + {tap[7], tap[7:0]};
			// RULE5 span by bandwidth
			wire signed [8:0]  dif  = cti_comp ? (9'(x1_r) - 9'(x3_r)) : (9'(x0_r) - 9'(x4_r));
			wire signed [13:0] cor  = ($signed(dif) * $signed({1'b0, cti_gain})) >>> 3;
			wire signed [13:0] mag  = cor[13] ? -cor : cor;
			// RULE6 coring of small terms
			wire signed [13:0] crd  = (mag < $signed({10'h000, cti_core})) ? 14'sh0000 : cor;
			wire signed [13:0] shp  = 14'(x2_r) + crd;
			wire signed [7:0]  lo   = (x1_r < x3_r) ? x1_r : x3_r;
			wire signed [7:0]  hi   = (x1_r < x3_r) ? x3_r : x1_r;
			// RULE6 clamp to neighbours
			wire signed [7:0]  lim  = (shp < 14'(lo)) ? lo : (shp > 14'(hi)) ? hi : shp[7:0];

			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					{s1_r, x0_r, x1_r, x2_r, x3_r, x4_r, cti_r} <= 56'h0;
				end else begin
					if (newc) begin
						s1_r <= tap[7:0];
					end
					// RULE4 midpoint then sample
					x0_r  <= newc ? avs[8:1] : s1_r;
					x1_r  <= x0_r;
					x2_r  <= x1_r;
					x3_r  <= x2_r;
					x4_r  <= x3_r;
					cti_r <= lim;
				end
			end

			assign chr_q[c] = cti_r;
		end
	endgenerate

	// ==========================================
	// Side information pipe and border window
	wire [10:0] b_left  = regs_r[disp_pkg::BRD_LEFT][10:0];
	wire [10:0] b_right = regs_r[disp_pkg::BRD_RIGHT][10:0];
	wire [9:0]  b_top   = regs_r[disp_pkg::BRD_TOP][9:0];
	wire [9:0]  b_bot   = regs_r[disp_pkg::BRD_BOT][9:0];
	wire [10:0] h_act   = regs_r[disp_pkg::H_ACTIVE][10:0];
	wire [9:0]  v_act   = regs_r[disp_pkg::V_ACTIVE][9:0];
	// RULE15 right edge through flyback to left
	wire        brd_h   = (hpos_in >= h_act - b_right) || (hpos_in < b_left);
	wire        brd_v   = (vpos_in >= v_act - b_bot) || (vpos_in < b_top);
	disp_pkg::side_s sd_r [0:disp_pkg::SIDE_LAT-1];
	disp_pkg::side_s sd;

	// RULE24 side data matched to chroma
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < disp_pkg::SIDE_LAT; i++) begin
				sd_r[i] <= '0;
			end
		end else begin
			// RULE23 lines taken on display clock
			sd_r[0] <= '{luma: luma_in, osd: osd_in, rank: overlay_rank_bus_in, border: brd_h || brd_v};
			for (int i = 1; i < disp_pkg::SIDE_LAT; i++) begin
				sd_r[i] <= sd_r[i-1];
			end
		end
	end

	assign sd = sd_r[disp_pkg::SIDE_LAT-1];

	// ==========================================
	// Priority decode, matrix and insertion
	// RULE18 level 0 is highest
	wire [5:0]  ctl     = regs_r[disp_pkg::RANK_TAB + 7'(sd.rank)][5:0];
	// RULE8 per pixel coefficient set
	wire [6:0]  cbase   = ctl[disp_pkg::CTL_SIDE] ? disp_pkg::COEF_SIDE : disp_pkg::COEF_MAIN;
	// RULE17 border only above bus level
	wire        brd_hit = sd.border && (regs_r[disp_pkg::BRD_RANK][2:0] < sd.rank);
	wire [15:0] otab_w  = regs_r[disp_pkg::OSD_TAB + 7'(sd.osd[3:0])];
	logic [5:0] ctl_r;
	logic [5:0] ctl2_r;
	logic [9:0] mix_r [0:2];
	logic [9:0] rgb_r [0:2];

	function automatic logic [9:0] sat_u(input logic [10:0] v);
		sat_u = v[10] ? 10'h3ff : v[9:0];
	endfunction : sat_u

	generate
		for (genvar k = 0; k < 3; k++) begin : g_chan
			// RULE7 signed 9-bit pair
			wire signed [8:0]  kcb  = regs_r[cbase + 7'(2*k)][8:0];
			wire signed [8:0]  kcr  = regs_r[cbase + 7'(2*k+1)][8:0];
			wire signed [16:0] pb   = kcb * chr_q[0];
			wire signed [16:0] pr   = kcr * chr_q[1];
			wire signed [17:0] dsum = 18'(pb) + 18'(pr);
			wire signed [13:0] vsum = 14'(dsum >>> 6) + $signed({4'h0, sd.luma});
			// RULE9 clip to 10 bits
			wire [9:0]  vid  = vsum[13] ? 10'h000 : (vsum > 14'sd1023) ? 10'h3ff : vsum[9:0];
			wire [3:0]  cn   = otab_w[4*k +: 4];
			// RULE16 border nibble and contrast
			wire [3:0]  bn   = regs_r[disp_pkg::BRD_COL][4*k +: 4];
			wire [17:0] bsc  = {bn, bn, bn[3:2]} * regs_r[disp_pkg::BRD_CON][7:0];
			// RULE12 fixed colours, half contrast
			wire [9:0]  fixv = sd.osd[k] ? (sd.osd[3] ? 10'h1ff : 10'h3ff) : 10'h000;
			// RULE11 five-bit table address
			wire [9:0]  osdv = sd.osd[4] ? {cn, cn, cn[3:2]} : fixv;
			// RULE14 per channel amplitude
			wire [17:0] osc  = osdv * regs_r[disp_pkg::OSD_AMP + 7'(k)][7:0];
			wire [7:0]  wd   = regs_r[disp_pkg::WDRIVE + 7'(k)][7:0];
			wire [15:0] wp   = wd * abl_atten_in;
			// RULE10 drive less attenuation
			wire [7:0]  eff  = wd - wp[15:8];
			wire [17:0] outp = mix_r[k] * eff;

			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					mix_r[k] <= 10'h000;
					rgb_r[k] <= 10'h000;
				end else begin
					// RULE14 priority picks source
					mix_r[k] <= brd_hit ? sat_u(bsc[17:7]) : ctl[disp_pkg::CTL_TAB] ? sat_u(osc[17:7]) : vid;
					rgb_r[k] <= sat_u(outp[17:7]);
				end
			end
		end
	endgenerate

	// RULE19 controls follow pixel
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ctl_r  <= 6'h00;
			ctl2_r <= 6'h00;
			brd_r  <= 1'b0;
			rank_r <= 3'h0;
		end else begin
			ctl_r  <= ctl;
			ctl2_r <= ctl_r;
			brd_r  <= brd_hit;
			rank_r <= sd.rank;
		end
	end

	assign red_out          = rgb_r[0];
	assign green_out        = rgb_r[1];
	assign blue_out         = rgb_r[2];
	assign side_sel_out     = ctl2_r[disp_pkg::CTL_SIDE];
	assign table_sel_out    = ctl2_r[disp_pkg::CTL_TAB];
	assign black_exp_en_out = ctl2_r[disp_pkg::CTL_BEXP];
	assign peak_supp_out    = ctl2_r[disp_pkg::CTL_PEAK];
	assign fblank1_en_out   = ctl2_r[disp_pkg::CTL_FB1];
	assign fblank2_en_out   = ctl2_r[disp_pkg::CTL_FB2];

	// ==========================================
	// Scan velocity modulation
	wire [17:0] ysum   = 18'(mix_r[0] * 8'd77) + 18'(mix_r[1] * 8'd150) + 18'(mix_r[2] * 8'd29);
	// RULE22 set follows source switch
	wire [15:0] sv_cfg = regs_r[ctl_r[disp_pkg::CTL_TAB] ? disp_pkg::VEL_SET1 : disp_pkg::VEL_SET0];
	wire [2:0]  sv_n   = (sv_cfg[2:0] == 3'h0) ? 3'h1 : (sv_cfg[2:0] == 3'h7) ? 3'h6 : sv_cfg[2:0];
	wire [15:0] sv_cor = regs_r[disp_pkg::VEL_CORE];
	wire [3:0]  sv_dly = (regs_r[disp_pkg::VEL_DLY][3:0] == 4'hf) ? 4'he : regs_r[disp_pkg::VEL_DLY][3:0];
	logic [9:0]        yh_r [0:6];
	logic signed [7:0] sv_r [0:disp_pkg::SV_DEPTH-1];
	logic [7:0]        vel_r;
	// RULE20 difference over N pixels
	wire signed [10:0] yd   = $signed({1'b0, yh_r[0]}) - $signed({1'b0, yh_r[sv_n]});
	wire signed [10:0] ymag = yd[10] ? -yd : yd;
	wire signed [10:0] ydc  = (ymag < $signed({7'h00, sv_cor[3:0]})) ? 11'sh000 : yd;
	wire signed [15:0] yg   = (ydc * $signed({1'b0, sv_cfg[7:4]})) >>> 3;
	wire signed [15:0] slim = $signed({9'h000, sv_cor[10:4]});
	wire signed [7:0]  svl  = (yg > slim) ? slim[7:0] : (yg < -slim) ? 8'(-slim) : yg[7:0];
	wire [2:0]         sidx = sv_dly[3:1];
	wire signed [8:0]  savg = 9'(sv_r[sidx]) + 9'(sv_r[3'(sidx + 3'h1)]);
	// RULE21 half step by averaging
	wire signed [7:0]  svd  = sv_dly[0] ? savg[8:1] : sv_r[sidx];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < 7; i++) begin
				yh_r[i] <= 10'h000;
			end
			for (int i = 0; i < disp_pkg::SV_DEPTH; i++) begin
				sv_r[i] <= 8'sh00;
			end
			vel_r <= 8'h80;
		end else begin
			yh_r[0] <= ysum[17:8];
			for (int i = 1; i < 7; i++) begin
				yh_r[i] <= yh_r[i-1];
			end
			sv_r[0] <= svl;
			for (int i = 1; i < disp_pkg::SV_DEPTH; i++) begin
				sv_r[i] <= sv_r[i-1];
			end
			// RULE20 offset coded output
			vel_r <= svd ^ 8'h80;
		end
	end

	assign beam_velocity_modulation_out = vel_r;

endmodule : display_chroma_rgb_osd_pipeline

/* File: testbench/disp_asserts.sv */
// Register bus and control timing checks for the display path
`timescale 1ns/10ps
module disp_asserts (
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic [6:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [2:0]  overlay_rank_bus_in,
	input wire logic [9:0]  red_out,
	input wire logic [7:0]  beam_velocity_modulation_out,
	input wire logic        side_sel_out,
	input wire logic        table_sel_out,
	input wire logic        fblank2_en_out
);
	// ========================================
	// Ages since priority change and write
	logic [2:0] pr_r;
	logic [7:0] pq_r;
	logic [7:0] wq_r;
	wire        pchg = overlay_rank_bus_in != pr_r;
	wire  [2:0] ctl = {side_sel_out, table_sel_out, fblank2_en_out};
	always_ff @(posedge clock_in) begin
		pr_r <= overlay_rank_bus_in;
		pq_r <= (rst_in || pchg) ? 8'h00 : ((pq_r == 8'hff) ? pq_r : pq_r + 8'h01);
		wq_r <= (rst_in || reg_wr_in) ? 8'h00 : ((wq_r == 8'hff) ? wq_r : wq_r + 8'h01);
	end
	// ========================================
	// Assertions
	a_rdata_idle: assert property (@(posedge clock_in) disable iff (rst_in) !reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data not zero outside read");
	a_write_back: assert property (@(posedge clock_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in != disp_pkg::STATUS ##1 !reg_wr_in
		##1 reg_rd_in && reg_addr_in == $past(reg_addr_in, 2)
		|=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("written word not read back");
	a_status_ro: assert property (@(posedge clock_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == disp_pkg::STATUS |=> reg_rdata_out[15:4] == 12'h000)
		else $error("status upper bits not zero");
	a_reset_black: assert property (@(posedge clock_in) rst_in |=> red_out == 10'h000)
		else $error("rgb not black after reset");
	a_vel_rest: assert property (@(posedge clock_in) rst_in |=> beam_velocity_modulation_out == 8'h80)
		else $error("velocity output not centred after reset");
	a_ctl_reset: assert property (@(posedge clock_in) rst_in |=> ctl == 3'b000)
		else $error("control outputs set after reset");
	a_ctl_hold: assert property (@(posedge clock_in) disable iff (rst_in)
		pq_r >= 8'd11 && wq_r >= 8'd12 |-> $stable(ctl)) else $error("controls moved without cause");
	a_ctl_align: assert property (@(posedge clock_in) disable iff (rst_in)
		$changed(ctl) && wq_r >= 8'd12 |-> pq_r inside {[8'd8:8'd10]}) else $error("control latency wrong");
endmodule : disp_asserts
bind display_chroma_rgb_osd_pipeline disp_asserts disp_asserts_i (.clock_in(clock_in), .rst_in(rst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .overlay_rank_bus_in(overlay_rank_bus_in), .red_out(red_out),
	.beam_velocity_modulation_out(beam_velocity_modulation_out), .side_sel_out(side_sel_out),
	.table_sel_out(table_sel_out), .fblank2_en_out(fblank2_en_out));

/* File: testbench/display_chroma_rgb_osd_pipeline_tb.sv */
// Self-checking bench for the display path
`timescale 1ns/10ps
module display_chroma_rgb_osd_pipeline_tb;
	logic        clock_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [6:0]  reg_addr_in = 7'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic [7:0]  abl_atten_in = 8'h00;
	logic [4:0]  ow = 5'h00;
	logic [2:0]  pw = 3'h2;
	logic [10:0] hw = 11'h064;
	logic [7:0]  cw = 8'h80;
	logic [7:0]  vel;
	logic [7:0]  chroma;
	logic        cr;
	logic [9:0]  luma, vpos, red_out, green_out, blue_out;
	logic [4:0]  osd;
	logic [2:0]  rank;
	logic [10:0] hpos;
	logic [5:0]  ctl;
	logic [15:0] v;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc = 0;
	// ========================================
	// Clock, reset, timeout
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			give_verdict();
		end
	end
	front_src front_src_i (.clock_in(clock_in), .chroma_want_in(cw), .osd_want_in(ow), .rank_want_in(pw),
		.hpos_want_in(hw), .chroma_out(chroma), .cr_out(cr), .luma_out(luma), .osd_out(osd), .rank_out(rank),
		.hpos_out(hpos), .vpos_out(vpos));
	display_chroma_rgb_osd_pipeline display_chroma_rgb_osd_pipeline_i (.clock_in(clock_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .chroma_in(chroma), .chroma_cr_in(cr), .luma_in(luma), .osd_in(osd),
		.overlay_rank_bus_in(rank), .hpos_in(hpos), .vpos_in(vpos), .abl_atten_in(abl_atten_in),
		.red_out(red_out), .green_out(green_out), .blue_out(blue_out), .beam_velocity_modulation_out(vel),
		.side_sel_out(ctl[0]), .table_sel_out(ctl[1]),
		.black_exp_en_out(ctl[2]), .peak_supp_out(ctl[3]), .fblank1_en_out(ctl[4]), .fblank2_en_out(ctl[5]));
	// ========================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
		chk(v, exp);
	endtask : rdc
	task automatic pix(input logic [4:0] o, input logic [2:0] p, input logic [10:0] h);
		@(posedge clock_in);
		ow <= o;
		pw <= p;
		hw <= h;
		repeat (14) @(posedge clock_in);
		#1;
	endtask : pix
	task automatic rgb(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
		chk({6'h00, red_out}, {6'h00, r});
		chk({6'h00, green_out}, {6'h00, g});
		chk({6'h00, blue_out}, {6'h00, b});
	endtask : rgb
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// ========================================
	// Scenarios
	task automatic t_regs;
		rdc(disp_pkg::CHR_CFG, disp_pkg::CHR_RST);
		rdc(disp_pkg::CTI_CFG, disp_pkg::CTI_RST);
		rdc(disp_pkg::COEF_MAIN + 7'h01, disp_pkg::COEF_RST[1]);
		rdc(disp_pkg::COEF_SIDE + 7'h01, disp_pkg::COEF_RST[1]);
		rdc(disp_pkg::WDRIVE, disp_pkg::GAIN_RST);
		rdc(disp_pkg::VEL_CORE, disp_pkg::SVC_RST);
		rdc(disp_pkg::VEL_DLY, disp_pkg::SVD_RST);
		rdc(disp_pkg::VEL_SET1, disp_pkg::VEL_RST);
		wr(7'h7f, 16'ha5c3);
		rdc(7'h7f, 16'ha5c3);
		wr(disp_pkg::STATUS, 16'hffff);
		rdc(disp_pkg::STATUS, 16'h0002);
		$display("test regs done");
	endtask : t_regs
	task automatic t_osd;
		logic [4:0] o;
		logic [9:0] f;
		wr(disp_pkg::RANK_TAB, 16'h0002);
		for (int i = 0; i < 16; i++) begin
			o = i[4:0];
			f = o[3] ? 10'h1ff : 10'h3ff;
			pix(o, 3'h0, 11'h064);
			rgb(o[0] ? f : 10'h0, o[1] ? f : 10'h0, o[2] ? f : 10'h0);
			chk({15'h0, ctl[1]}, 16'h0001);
		end
		wr(disp_pkg::OSD_TAB + 7'h05, 16'h0a5c);
		wr(disp_pkg::OSD_AMP, 16'h0040);
		pix(5'h15, 3'h0, 11'h064);
		rgb(10'h199, 10'h155, 10'h2aa);
		wr(disp_pkg::OSD_AMP, 16'h0080);
		$display("test osd done");
	endtask : t_osd
	task automatic t_drive;
		wr(disp_pkg::WDRIVE, 16'h0040);
		pix(5'h07, 3'h0, 11'h064);
		rgb(10'h1ff, 10'h3ff, 10'h3ff);
		@(posedge clock_in);
		abl_atten_in <= 8'h80;
		pix(5'h07, 3'h0, 11'h064);
		rgb(10'h0ff, 10'h1ff, 10'h1ff);
		@(posedge clock_in);
		abl_atten_in <= 8'h00;
		wr(disp_pkg::WDRIVE, 16'h0080);
		$display("test drive done");
	endtask : t_drive
	task automatic t_border;
		wr(disp_pkg::BRD_TOP, 16'h0000);
		wr(disp_pkg::BRD_BOT, 16'h0000);
		wr(disp_pkg::BRD_RIGHT, 16'h0008);
		wr(disp_pkg::BRD_LEFT, 16'h000a);
		wr(disp_pkg::BRD_COL, 16'h00f0);
		wr(disp_pkg::BRD_CON, 16'h0080);
		wr(disp_pkg::BRD_RANK, 16'h0000);
		wr(disp_pkg::RANK_TAB + 7'h03, 16'h0000);
		pix(5'h00, 3'h3, 11'h005);
		rgb(10'h0, 10'h3ff, 10'h0);
		pix(5'h00, 3'h3, 11'h2cb);
		rgb(10'h0, 10'h3ff, 10'h0);
		pix(5'h00, 3'h3, 11'h064);
		rgb(10'h0, 10'h0, 10'h0);
		wr(disp_pkg::BRD_RANK, 16'h0007);
		pix(5'h00, 3'h3, 11'h005);
		rgb(10'h0, 10'h0, 10'h0);
		chk({8'h00, vel}, 16'h0080);
		$display("test border done");
	endtask : t_border
	task automatic t_ctl;
		for (int l = 0; l < 8; l++)
			wr(disp_pkg::RANK_TAB + l[6:0], 16'((l * 9 + 5) % 64));
		for (int l = 0; l < 8; l++) begin
			pix(5'h00, l[2:0], 11'h064);
			chk({10'h0, ctl}, 16'((l * 9 + 5) % 64));
		end
		$display("test control done");
	endtask : t_ctl
	task automatic t_chroma;
		@(posedge clock_in);
		cw <= 8'hc0;
		pix(5'h00, 3'h0, 11'h064);
		rgb(10'h05a, 10'h000, 10'h071);
		wr(disp_pkg::COEF_SIDE + 7'h01, 16'h0040);
		pix(5'h00, 3'h0, 11'h064);
		rgb(10'h040, 10'h000, 10'h071);
		wr(disp_pkg::CHR_CFG, 16'h0009);
		pix(5'h00, 3'h0, 11'h064);
		rgb(10'h000, 10'h044, 10'h000);
		wr(disp_pkg::CHR_CFG, 16'h000a);
		pix(5'h00, 3'h0, 11'h064);
		rgb(10'h000, 10'h044, 10'h000);
		$display("test chroma done");
	endtask : t_chroma
	initial begin
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		t_regs();
		t_osd();
		t_drive();
		t_border();
		t_ctl();
		t_chroma();
		give_verdict();
	end
endmodule : display_chroma_rgb_osd_pipeline_tb

/* File: testbench/front_src.sv */
// Front-end video, OSD and priority source model
`timescale 1ns/10ps
module front_src (
	input  wire logic        clock_in,
	input  wire logic [7:0]  chroma_want_in,
	input  wire logic [4:0]  osd_want_in,
	input  wire logic [2:0]  rank_want_in,
	input  wire logic [10:0] hpos_want_in,
	output logic      [7:0]  chroma_out = 8'h80,
	output logic             cr_out = 1'b0,
	output logic      [9:0]  luma_out,
	output logic      [4:0]  osd_out = 5'h00,
	output logic      [2:0]  rank_out = 3'h2,
	output logic      [10:0] hpos_out = 11'h064,
	output logic      [9:0]  vpos_out
);
	// Offset-coded chroma, Cb and Cr alternate
	assign luma_out = 10'h000;
	assign vpos_out = 10'h064;
	// Lines launched on the display clock
	always_ff @(posedge clock_in) begin
		chroma_out <= chroma_want_in;
		cr_out <= ~cr_out;
		osd_out <= osd_want_in;
		rank_out <= rank_want_in;
		hpos_out <= hpos_want_in;
	end
endmodule : front_src
